// ==== core/thermal_zone_defs.svh ====
// constants for the thermal zone alert logic
// Notes on behaviour
// - pulse 60uA out of the thermistor pin at 1kHz, 50% duty.
// - digitize thermistor pin voltage with the ADC to form the thermal zone code.
// - zone bit 6 rising sets alert cause bit 1.
// - a change of the alert cause bit asserts the alert request line.
// - after the host read completes, alert request is released.
// - zone bit 7 rising asserts the overtemperature throttle line.
// - zone bit 6 falling deasserts the throttle line unless bit 7 rises in the same update, giving hysteresis.
// - zone bit 5 falling clears alert cause bit 1 and reasserts alert request.
// - any voltage code change steps the DAC one 5mV code per 101 clocks (505ns), so it slews at about 9.9mV/us.
`ifndef THERMAL_ZONE_DEFS_SVH
`define THERMAL_ZONE_DEFS_SVH
`define CLK_PERIOD_PS 5000
`define NTC_PULSE_PERIOD_NS 1000000
`define NTC_HALF_CYCLES ((`NTC_PULSE_PERIOD_NS * 1000 / `CLK_PERIOD_PS) / 2)
`define NTC_CURRENT_UA 60
`define SLEW_MV_PER_US 10
`define DAC_STEP_UV 5000
`define SLEW_STEP_NS (`DAC_STEP_UV / `SLEW_MV_PER_US)
`define SLEW_STEP_CYCLES (`SLEW_STEP_NS * 1000 / `CLK_PERIOD_PS)
`define ZONE_ALERT_BIT 6
`define ZONE_HOT_BIT 7
`define ZONE_CLEAR_BIT 5
`define CAUSE_THERM_BIT 1
`define CAUSE_RESET 8'h00
`define VID_RESET 8'h00
`endif

// ==== core/thermal_zone_pkg.sv ====
// types for the thermal zone alert logic
package thermal_zone_pkg;
  typedef enum logic [1:0] {
    SLEW_IDLE = 2'b00,
    SLEW_WAIT = 2'b01,
    SLEW_STEP = 2'b11
  } slew_state_type;
  typedef struct packed {
    logic [7:0] cause;
    logic alert_n;
    logic throttle_n;
  } alert_out_type;
endpackage

// ==== core/thermal_zone_alert_logic.sv ====
// thermal zone monitor, alert and throttle signalling, vid slew stepper
`timescale 1ns/1ps
`default_nettype none
`include "thermal_zone_defs.svh"

// ----------------------------------------
// two flip-flop synchroniser
// ----------------------------------------
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

module thermal_zone_alert_logic #(
  parameter int NTC_HALF = `NTC_HALF_CYCLES,
  parameter int SLEW_CYC = `SLEW_STEP_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] adc_code_i,
  input wire logic adc_valid_i,
  input wire logic cause_read_i,
  input wire logic [7:0] vid_target_i,
  output logic ntc_pulse_o,
  output logic [7:0] zone_code_o,
  output logic [7:0] alert_cause_o,
  output logic alert_n_o,
  output logic overtemp_throttle_line_n_o,
  output logic [7:0] dac_code_o,
  output logic slewing_o
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [7:0] adc_sync;
  logic [7:0] tgt_sync;
  logic val_sync;
  logic rd_sync;
  logic val_d_r;
  logic rd_d_r;
  sync_two_ff #(
    .WIDTH(8)
  ) sync_two_ff_adc_inst (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(adc_code_i),
    .sync_o(adc_sync)
  );
  sync_two_ff #(
    .WIDTH(8)
  ) sync_two_ff_tgt_inst (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(vid_target_i),
    .sync_o(tgt_sync)
  );
  sync_two_ff #(
    .WIDTH(1)
  ) sync_two_ff_val_inst (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(adc_valid_i),
    .sync_o(val_sync)
  );
  sync_two_ff #(
    .WIDTH(1)
  ) sync_two_ff_rd_inst (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(cause_read_i),
    .sync_o(rd_sync)
  );
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_d_r <= 1'b0;
      rd_d_r <= 1'b0;
    end else begin
      val_d_r <= val_sync;
      rd_d_r <= rd_sync;
    end
  end
  wire adc_take = val_sync & ~val_d_r;
  // read done on falling edge of read strobe
  wire read_done = rd_d_r & ~rd_sync;

  // ----------------------------------------
  // thermistor current pulse
  // ----------------------------------------
  logic [31:0] ntc_cnt_r;
  wire ntc_wrap = (ntc_cnt_r == 32'(NTC_HALF - 1));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ntc_cnt_r <= 32'h0;
      ntc_pulse_o <= 1'b0;
    end else begin
      ntc_cnt_r <= ntc_wrap ? 32'h0 : ntc_cnt_r + 32'h1;
      if (ntc_wrap) begin
        ntc_pulse_o <= ~ntc_pulse_o;
      end
    end
  end

  // ----------------------------------------
  // zone code and alert logic
  // ----------------------------------------
  logic [7:0] zone_r;
  wire [7:0] zone_nxt = adc_take ? adc_sync : zone_r;
  wire b6_rise = ~zone_r[`ZONE_ALERT_BIT] & zone_nxt[`ZONE_ALERT_BIT];
  wire b6_fall = zone_r[`ZONE_ALERT_BIT] & ~zone_nxt[`ZONE_ALERT_BIT];
  wire b7_rise = ~zone_r[`ZONE_HOT_BIT] & zone_nxt[`ZONE_HOT_BIT];
  wire b5_fall = zone_r[`ZONE_CLEAR_BIT] & ~zone_nxt[`ZONE_CLEAR_BIT];
  wire cause_set = b6_rise & ~alert_cause_o[`CAUSE_THERM_BIT];
  wire cause_clr = b5_fall & alert_cause_o[`CAUSE_THERM_BIT];
  wire cause_chg = cause_set | cause_clr;
  thermal_zone_pkg::alert_out_type alert_nxt;
  always_comb begin
    alert_nxt.cause = alert_cause_o;
    alert_nxt.alert_n = alert_n_o;
    alert_nxt.throttle_n = overtemp_throttle_line_n_o;
    if (cause_set) begin
      alert_nxt.cause[`CAUSE_THERM_BIT] = 1'b1;
    end else if (cause_clr) begin
      alert_nxt.cause[`CAUSE_THERM_BIT] = 1'b0;
    end
    // a new change wins over a read completing in the same cycle
    if (cause_chg) begin
      alert_nxt.alert_n = 1'b0;
    end else if (read_done) begin
      alert_nxt.alert_n = 1'b1;
    end
    if (b7_rise) begin
      alert_nxt.throttle_n = 1'b0;
    end else if (b6_fall) begin
      alert_nxt.throttle_n = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zone_r <= 8'h00;
      zone_code_o <= 8'h00;
      alert_cause_o <= `CAUSE_RESET;
      alert_n_o <= 1'b1;
      overtemp_throttle_line_n_o <= 1'b1;
    end else begin
      zone_r <= zone_nxt;
      zone_code_o <= zone_nxt;
      alert_cause_o <= alert_nxt.cause;
      alert_n_o <= alert_nxt.alert_n;
      overtemp_throttle_line_n_o <= alert_nxt.throttle_n;
    end
  end

  // ----------------------------------------
  // dac slew stepper
  // ----------------------------------------
  thermal_zone_pkg::slew_state_type st_r;
  thermal_zone_pkg::slew_state_type st_nxt;
  logic [31:0] slew_cnt_r;
  logic [31:0] slew_cnt_nxt;
  logic [7:0] dac_nxt;
  logic slewing_nxt;
  wire slew_due = (slew_cnt_r == 32'(SLEW_CYC - 1));
  wire at_tgt = (dac_code_o == tgt_sync);
  wire [7:0] dac_step = (tgt_sync > dac_code_o) ? dac_code_o + 8'h01 : dac_code_o - 8'h01;
  always_comb begin
    st_nxt = st_r;
    slew_cnt_nxt = slew_cnt_r;
    dac_nxt = dac_code_o;
    slewing_nxt = slewing_o;
    case (st_r)
      thermal_zone_pkg::SLEW_IDLE: begin
        slew_cnt_nxt = 32'h0;
        if (!at_tgt) begin
          st_nxt = thermal_zone_pkg::SLEW_WAIT;
          slewing_nxt = 1'b1;
        end
      end
      thermal_zone_pkg::SLEW_WAIT: begin
        slew_cnt_nxt = slew_cnt_r + 32'h1;
        if (slew_due) begin
          st_nxt = thermal_zone_pkg::SLEW_STEP;
        end
      end
      thermal_zone_pkg::SLEW_STEP: begin
        slew_cnt_nxt = 32'h0;
        if (at_tgt) begin
          st_nxt = thermal_zone_pkg::SLEW_IDLE;
          slewing_nxt = 1'b0;
        end else begin
          dac_nxt = dac_step;
          st_nxt = thermal_zone_pkg::SLEW_WAIT;
        end
      end
      default: begin
        st_nxt = thermal_zone_pkg::SLEW_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= thermal_zone_pkg::SLEW_IDLE;
      slew_cnt_r <= 32'h0;
      dac_code_o <= `VID_RESET;
      slewing_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      slew_cnt_r <= slew_cnt_nxt;
      dac_code_o <= dac_nxt;
      slewing_o <= slewing_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/thermal_zone_alert_logic_assertions.sv ====
// concurrent checks on the thermal zone alert logic ports
`timescale 1ns/1ps
`default_nettype none
module tza_checker #(
  parameter int NTC_HALF = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] adc_code_i,
  input wire logic adc_valid_i,
  input wire logic cause_read_i,
  input wire logic ntc_pulse_o,
  input wire logic [7:0] zone_code_o,
  input wire logic [7:0] alert_cause_o,
  input wire logic alert_n_o,
  input wire logic overtemp_throttle_line_n_o,
  input wire logic [7:0] dac_code_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ntc; $rose(ntc_pulse_o) |-> ntc_pulse_o[*4] ##1 !ntc_pulse_o; endproperty
  a_ntc: assert property (p_ntc) else $error("pulse half period off");
  property p_cap; $rose(adc_valid_i) |-> ##[4:5] zone_code_o == $past(adc_code_i); endproperty
  a_cap: assert property (p_cap) else $error("zone code not captured");
  property p_set; $rose(zone_code_o[6]) && !$past(alert_cause_o[1]) |-> alert_cause_o[1] && !alert_n_o; endproperty
  a_set: assert property (p_set) else $error("cause not set on rise");
  property p_clr; $fell(zone_code_o[5]) && $past(alert_cause_o[1]) |-> !alert_cause_o[1] && !alert_n_o; endproperty
  a_clr: assert property (p_clr) else $error("cause not cleared on fall");
  property p_hot; $rose(zone_code_o[7]) |-> !overtemp_throttle_line_n_o; endproperty
  a_hot: assert property (p_hot) else $error("throttle not asserted");
  property p_cool; $fell(zone_code_o[6]) |-> overtemp_throttle_line_n_o; endproperty
  a_cool: assert property (p_cool) else $error("throttle not released");
  property p_rel; $rose(alert_n_o) |-> !$past(cause_read_i, 3) && $past(cause_read_i, 4); endproperty
  a_rel: assert property (p_rel) else $error("alert released off read");
  property p_slew; $changed(dac_code_o) |-> (dac_code_o - $past(dac_code_o) == 8'h01 ||
    $past(dac_code_o) - dac_code_o == 8'h01) ##1 $stable(dac_code_o)[*3]; endproperty
  a_slew: assert property (p_slew) else $error("dac step wrong");
endmodule
bind thermal_zone_alert_logic tza_checker #(.NTC_HALF(NTC_HALF)) tza_checker_inst (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .adc_code_i(adc_code_i), .adc_valid_i(adc_valid_i), .cause_read_i(cause_read_i),
  .ntc_pulse_o(ntc_pulse_o), .zone_code_o(zone_code_o), .alert_cause_o(alert_cause_o), .alert_n_o(alert_n_o),
  .overtemp_throttle_line_n_o(overtemp_throttle_line_n_o), .dac_code_o(dac_code_o));
`default_nettype wire

// ==== testbench/host_model.sv ====
// host side: reads the alert cause once alert request goes low
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic alert_n_i,
  output var logic cause_read_o = 1'b0
);
  int cnt = 0;
  always @(negedge clk_i) begin
    if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 7) cause_read_o <= 1'b0;
    else if (cnt == 0 && !alert_n_i) begin
      cause_read_o <= 1'b1;
      cnt <= 9;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/thermal_zone_alert_logic_test.sv ====
// directed tests of the thermal zone alert logic
`timescale 1ns/1ps
`default_nettype none
module thermal_zone_alert_logic_test;
  logic sys_clk_i, rst_n_i = 1'b0, adc_valid_i = 1'b0, cause_read_i, ntc_pulse_o, alert_n_o, thr_n, slewing_o;
  logic [7:0] adc_code_i = 8'h00, vid_target_i = 8'h00, zone_code_o, alert_cause_o, dac_code_o;
  int n_errors = 0, total_checks = 0;
  thermal_zone_alert_logic #(.NTC_HALF(4), .SLEW_CYC(3)) thermal_zone_alert_logic_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .adc_code_i(adc_code_i), .adc_valid_i(adc_valid_i), .cause_read_i(cause_read_i),
    .vid_target_i(vid_target_i), .ntc_pulse_o(ntc_pulse_o), .zone_code_o(zone_code_o),
    .alert_cause_o(alert_cause_o), .alert_n_o(alert_n_o), .overtemp_throttle_line_n_o(thr_n),
    .dac_code_o(dac_code_o), .slewing_o(slewing_o));
  host_model host_model_inst (.clk_i(sys_clk_i), .alert_n_i(alert_n_o), .cause_read_o(cause_read_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic conv(logic [7:0] code);
    @(negedge sys_clk_i) adc_code_i = code;
    repeat (3) @(negedge sys_clk_i);
    adc_valid_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    adc_valid_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk("zone", zone_code_o, code);
  endtask
  task automatic slew(logic [7:0] t);
    @(negedge sys_clk_i) vid_target_i = t;
    repeat (40) @(negedge sys_clk_i);
    chk("dac", dac_code_o, t);
    chk("slewing", {7'h00, slewing_o}, 8'h00);
    $display("test slew done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i) rst_n_i = 1'b1;
    chk("reset", {alert_cause_o[3:0], alert_n_o, thr_n, 2'b00}, 8'h0c);
    @(posedge ntc_pulse_o);
    repeat (4) @(negedge sys_clk_i);
    chk("ntc", {7'h00, ntc_pulse_o}, 8'h01);
    @(negedge sys_clk_i);
    chk("ntc", {7'h00, ntc_pulse_o}, 8'h00);
    conv(8'h40);
    chk("cause", alert_cause_o, 8'h02);
    chk("alert", {7'h00, alert_n_o}, 8'h00);
    repeat (12) @(negedge sys_clk_i);
    chk("alert", {7'h00, alert_n_o}, 8'h01);
    conv(8'hc0);
    chk("throttle", {7'h00, thr_n}, 8'h00);
    conv(8'h20);
    chk("throttle", {7'h00, thr_n}, 8'h01);
    chk("cause", alert_cause_o, 8'h02);
    conv(8'h00);
    chk("cause", alert_cause_o, 8'h00);
    chk("alert", {7'h00, alert_n_o}, 8'h00);
    repeat (12) @(negedge sys_clk_i);
    chk("alert", {7'h00, alert_n_o}, 8'h01);
    $display("test zone done");
    slew(8'h05);
    slew(8'h02);
    summarize;
  end
endmodule
`default_nettype wire
